// ---- rtl/wfm_pkg.sv ----
// Constants, register map and helpers for the wake frame and magic packet detector
package wfm_pkg;

  // Register byte offsets on the APB bus
  localparam logic [11:0] WFM_REG_WAKE_CTRL_STATUS = 12'h000;
  localparam logic [11:0] WFM_REG_CMD_LO = 12'h004;
  localparam logic [11:0] WFM_REG_CMD_HI = 12'h008;
  localparam logic [11:0] WFM_REG_OFS_LO = 12'h00C;
  localparam logic [11:0] WFM_REG_OFS_HI = 12'h010;
  localparam logic [11:0] WFM_REG_CRC_01 = 12'h014;
  localparam logic [11:0] WFM_REG_CRC_23 = 12'h018;
  localparam logic [11:0] WFM_REG_CRC_45 = 12'h01C;
  localparam logic [11:0] WFM_REG_CRC_67 = 12'h020;
  localparam logic [11:0] WFM_REG_IRQ_STATUS = 12'h030;
  localparam logic [11:0] WFM_REG_IRQ_CLEAR = 12'h034;
  localparam logic [11:0] WFM_REG_IRQ_ENABLE = 12'h038;
  // Byte masks: 0x100 + filter*16 + word*4
  localparam logic [4:0] WFM_MASK_REGION = 5'h02;

  // Wake control/status field positions
  localparam int unsigned WFM_MAGIC_EN_BIT = 1;
  localparam int unsigned WFM_FRAME_EN_BIT = 2;
  localparam int unsigned WFM_MAGIC_RCVD_BIT = 5;
  localparam int unsigned WFM_FRAME_RCVD_BIT = 6;
  localparam int unsigned WFM_GLOBAL_UCAST_BIT = 9;

  // Filter command field positions and address types
  localparam int unsigned WFM_CMD_ENABLE_BIT = 0;
  localparam int unsigned WFM_CMD_ATYPE_LO = 2;
  localparam int unsigned WFM_CMD_ATYPE_HI = 3;
  localparam logic [1:0] WFM_ATYPE_UCAST = 2'b00;
  localparam logic [1:0] WFM_ATYPE_MCAST = 2'b10;

  // Interrupt status bit positions
  localparam int unsigned WFM_IRQ_FRAME_BIT = 0;
  localparam int unsigned WFM_IRQ_MAGIC_BIT = 1;

  // Reset values
  localparam logic [3:0] WFM_CMD_RESET = 4'h0;
  localparam logic [7:0] WFM_OFS_RESET = 8'h00;
  localparam logic [15:0] WFM_CRC_RESET = 16'h0000;
  localparam logic [31:0] WFM_MASK_RESET = 32'h00000000;
  localparam logic [1:0] WFM_IRQ_RESET = 2'h0;
  localparam logic [15:0] WFM_CRC_INIT = 16'hFFFF;

  // Frame layout counts
  localparam logic [3:0] WFM_HDR_BYTES = 4'hC;
  localparam logic [2:0] WFM_SYNC_BYTES = 3'h6;
  localparam logic [2:0] WFM_ADDR_BYTES = 3'h6;
  localparam logic [4:0] WFM_ADDR_COPIES = 5'h10;
  localparam logic [7:0] WFM_SYNC_BYTE = 8'hFF;

  // Magic packet search states
  typedef enum logic [2:0] {
    WFM_MG_HDR = 3'b001,
    WFM_MG_SYNC = 3'b010,
    WFM_MG_ADDR = 3'b100
  } wfm_magic_state_type;

  // One byte of CRC-16, bits taken lsb first as on the wire
  function automatic logic [15:0] wfm_crc16_byte(input logic [15:0] crc, input logic [7:0] data,
                                                 input logic [15:0] poly);
    logic [15:0] c;
    c = crc;
    for (int b = 0; b < 8; b++) begin
      if (c[15] ^ data[b]) begin
        c = {c[14:0], 1'b0} ^ poly;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

// ---- rtl/wfm_wake_detect.sv ----
// Wake frame pattern filters and magic packet detector with APB registers
//
// Function
// RULE1: address type 00 unicast, 10 multicast, x1 all
// RULE2: disabled filter never matches
// RULE3: CRC window starts at byte offset from DA
// RULE4: computed CRC-16 equal to expected means wake frame
// RULE5: frame wake only with wake frame enable set
// RULE6: broadcast CRC match wakes despite broadcast reject
// RULE7: global unicast bit: unicast CRC match wakes
// RULE8: else needs regular filter pass and address type
// RULE9: magic enable suppresses reception, starts detection
// RULE10: magic packet sets flag, resumes, signals wakeup; the code keeps O_RX_SUPPRESS set until software clears magic enable
// RULE11: software reads cause, clears flag and enable
// RULE12: examine own, broadcast or multicast destination frames
// RULE13: search after addresses for six FF bytes
// RULE14: then sixteen back-to-back station address copies
// RULE15: broken copy run restarts sync search
// RULE16: sync plus copies accepted anywhere in payload
// RULE17: 128-bit byte mask selects CRC bytes
// RULE18: mask lsb is earliest byte on the wire
// RULE19: all eight filters run in parallel, any wakes
`timescale 1ns/1ps
`default_nettype none
module wfm_wake_detect
  import wfm_pkg::*;
#(
  parameter int unsigned NUM_FILTERS = 8,
  parameter logic [15:0] CRC_POLY = 16'h8005
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RX_VALID,
  input wire logic [7:0] I_RX_DATA,
  input wire logic I_RX_LAST,
  input wire logic I_RX_PASS_FILTER,
  input wire logic [47:0] I_STATION_ADDR,
  output logic O_RX_SUPPRESS,
  output logic O_REMOTE_WAKE,
  output logic O_FULL_POWER,
  output logic O_IRQ
);

  // Bus handshake
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic access;
  logic commit;
  logic wr;
  logic addr_hit;
  logic [31:0] rd_data;
  logic in_mask;
  logic [2:0] mask_fidx;
  logic [1:0] mask_word;

  // Control and status
  logic magic_en_q;
  logic frame_en_q;
  logic magic_rcvd_q;
  logic frame_rcvd_q;
  logic global_ucast_q;
  logic [3:0] cmd_q [NUM_FILTERS];
  logic [7:0] ofs_q [NUM_FILTERS];
  logic [15:0] exp_crc_q [NUM_FILTERS];
  logic [127:0] mask_q [NUM_FILTERS];
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_en_q;
  logic [1:0] irq_events;

  // Receive tracking
  logic [8:0] pos_q;
  logic broadcast_reject_q;
  logic mcast_q;
  logic da_self_q;
  logic [7:0] sta_byte [6];
  logic frame_end;
  logic frame_wake;
  logic magic_evt;
  logic [NUM_FILTERS-1:0] hit;
  logic [15:0] crc_q [NUM_FILTERS];

  // Magic search
  wfm_magic_state_type mg_state_q;
  logic [3:0] hdr_cnt_q;
  logic [2:0] sync_cnt_q;
  logic [2:0] bidx_q;
  logic [4:0] copy_q;
  logic found_q;

  // Output flops
  logic remote_wake_q;
  logic full_power_q;
  logic irq_q;

  assign access = I_PSEL & I_PENABLE & ~pready_q;
  assign commit = I_PSEL & I_PENABLE & pready_q;
  assign wr = commit & I_PWRITE;
  assign in_mask = (I_PADDR[11:7] == WFM_MASK_REGION);
  assign mask_fidx = I_PADDR[6:4];
  assign mask_word = I_PADDR[3:2];
  assign frame_end = I_RX_VALID & I_RX_LAST;

  // Station address bytes, first on the wire in the top byte
  for (genvar k = 0; k < 6; k++) begin : g_sta
    assign sta_byte[k] = I_STATION_ADDR[47-8*k -: 8];
  end

  // Read data mux and address decode
  always_comb begin
    rd_data = 32'h00000000;
    addr_hit = 1'b1;
    if (in_mask) begin
      rd_data = mask_q[mask_fidx][32*mask_word +: 32];
    end else begin
      case ({I_PADDR[11:2], 2'b00})
        WFM_REG_WAKE_CTRL_STATUS: begin
          rd_data[WFM_MAGIC_EN_BIT] = magic_en_q;
          rd_data[WFM_FRAME_EN_BIT] = frame_en_q;
          rd_data[WFM_MAGIC_RCVD_BIT] = magic_rcvd_q;
          rd_data[WFM_FRAME_RCVD_BIT] = frame_rcvd_q;
          rd_data[WFM_GLOBAL_UCAST_BIT] = global_ucast_q;
        end
        WFM_REG_CMD_LO: begin
          rd_data = {4'h0, cmd_q[3], 4'h0, cmd_q[2], 4'h0, cmd_q[1], 4'h0, cmd_q[0]};
        end
        WFM_REG_CMD_HI: begin
          rd_data = {4'h0, cmd_q[7], 4'h0, cmd_q[6], 4'h0, cmd_q[5], 4'h0, cmd_q[4]};
        end
        WFM_REG_OFS_LO: rd_data = {ofs_q[3], ofs_q[2], ofs_q[1], ofs_q[0]};
        WFM_REG_OFS_HI: rd_data = {ofs_q[7], ofs_q[6], ofs_q[5], ofs_q[4]};
        WFM_REG_CRC_01: rd_data = {exp_crc_q[1], exp_crc_q[0]};
        WFM_REG_CRC_23: rd_data = {exp_crc_q[3], exp_crc_q[2]};
        WFM_REG_CRC_45: rd_data = {exp_crc_q[5], exp_crc_q[4]};
        WFM_REG_CRC_67: rd_data = {exp_crc_q[7], exp_crc_q[6]};
        WFM_REG_IRQ_STATUS: rd_data = {30'h00000000, irq_stat_q};
        WFM_REG_IRQ_CLEAR: rd_data = 32'h00000000;
        WFM_REG_IRQ_ENABLE: rd_data = {30'h00000000, irq_en_q};
        default: addr_hit = 1'b0;
      endcase
    end
  end

  // APB answer: one wait state, then ready with data or error
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access;
      if (access) begin
        prdata_q <= I_PWRITE ? 32'h00000000 : rd_data;
        pslverr_q <= ~addr_hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Wake control bits; received flags are write-one-to-clear, set wins
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      magic_en_q <= 1'b0;
      frame_en_q <= 1'b0;
      global_ucast_q <= 1'b0;
      magic_rcvd_q <= 1'b0;
      frame_rcvd_q <= 1'b0;
    end else begin
      if (wr && !in_mask && I_PADDR[11:2] == WFM_REG_WAKE_CTRL_STATUS[11:2]) begin
        magic_en_q <= I_PWDATA[WFM_MAGIC_EN_BIT]; // see RULE9
        frame_en_q <= I_PWDATA[WFM_FRAME_EN_BIT];
        global_ucast_q <= I_PWDATA[WFM_GLOBAL_UCAST_BIT];
        if (I_PWDATA[WFM_MAGIC_RCVD_BIT]) begin
          magic_rcvd_q <= 1'b0; // see RULE11
        end
        if (I_PWDATA[WFM_FRAME_RCVD_BIT]) begin
          frame_rcvd_q <= 1'b0;
        end
      end
      if (magic_evt) begin
        magic_rcvd_q <= 1'b1; // see RULE10
      end
      if (frame_wake) begin
        frame_rcvd_q <= 1'b1;
      end
    end
  end

  // Per-filter command, offset, expected CRC and byte mask registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      for (int f = 0; f < NUM_FILTERS; f++) begin
        cmd_q[f] <= WFM_CMD_RESET;
        ofs_q[f] <= WFM_OFS_RESET;
        exp_crc_q[f] <= WFM_CRC_RESET;
        mask_q[f] <= {4{WFM_MASK_RESET}};
      end
    end else if (wr) begin
      if (in_mask) begin
        mask_q[mask_fidx][32*mask_word +: 32] <= I_PWDATA; // see RULE18
      end else begin
        for (int f = 0; f < 4; f++) begin
          if (I_PADDR[11:2] == WFM_REG_CMD_LO[11:2]) begin
            cmd_q[f] <= I_PWDATA[8*f +: 4];
          end
          if (I_PADDR[11:2] == WFM_REG_CMD_HI[11:2]) begin
            cmd_q[f+4] <= I_PWDATA[8*f +: 4];
          end
          if (I_PADDR[11:2] == WFM_REG_OFS_LO[11:2]) begin
            ofs_q[f] <= I_PWDATA[8*f +: 8];
          end
          if (I_PADDR[11:2] == WFM_REG_OFS_HI[11:2]) begin
            ofs_q[f+4] <= I_PWDATA[8*f +: 8];
          end
        end
        for (int p = 0; p < 2; p++) begin
          if (I_PADDR[11:2] == WFM_REG_CRC_01[11:2]) begin
            exp_crc_q[p] <= I_PWDATA[16*p +: 16];
          end
          if (I_PADDR[11:2] == WFM_REG_CRC_23[11:2]) begin
            exp_crc_q[p+2] <= I_PWDATA[16*p +: 16];
          end
          if (I_PADDR[11:2] == WFM_REG_CRC_45[11:2]) begin
            exp_crc_q[p+4] <= I_PWDATA[16*p +: 16];
          end
          if (I_PADDR[11:2] == WFM_REG_CRC_67[11:2]) begin
            exp_crc_q[p+6] <= I_PWDATA[16*p +: 16];
          end
        end
      end
    end
  end

  // Frame byte position and destination address class
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      pos_q <= 9'h000;
      broadcast_reject_q <= 1'b0;
      mcast_q <= 1'b0;
      da_self_q <= 1'b0;
    end else if (I_RX_VALID) begin
      if (I_RX_LAST) begin
        pos_q <= 9'h000;
      end else if (pos_q != 9'h1FF) begin
        pos_q <= pos_q + 9'h001;
      end
      if (pos_q == 9'h000) begin
        broadcast_reject_q <= (I_RX_DATA == 8'hFF);
        mcast_q <= I_RX_DATA[0];
        da_self_q <= (I_RX_DATA == sta_byte[0]);
      end else if (pos_q < 9'h006) begin
        broadcast_reject_q <= broadcast_reject_q & (I_RX_DATA == 8'hFF);
        da_self_q <= da_self_q & (I_RX_DATA == sta_byte[pos_q[2:0]]);
      end
    end
  end

  // Pattern filters, all evaluated side by side on each byte
  for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_filt
    logic [8:0] rel;
    logic take;
    logic [15:0] crc_base;
    logic [15:0] crc_next;
    logic [1:0] atype;
    logic qualify;

    assign rel = pos_q - {1'b0, ofs_q[g]}; // see RULE3
    assign take = (pos_q >= {1'b0, ofs_q[g]}) && (rel < 9'h080) && mask_q[g][rel[6:0]]; // see RULE17
    assign crc_base = (pos_q == 9'h000) ? WFM_CRC_INIT : crc_q[g];
    assign crc_next = take ? wfm_crc16_byte(crc_base, I_RX_DATA, CRC_POLY) : crc_base;
    assign atype = cmd_q[g][WFM_CMD_ATYPE_HI:WFM_CMD_ATYPE_LO];

    // Address qualification of a CRC match
    always_comb begin
      qualify = 1'b0;
      if (broadcast_reject_q) begin
        qualify = 1'b1; // see RULE6
      end else if (global_ucast_q && !mcast_q) begin
        qualify = 1'b1; // see RULE7
      end else if (I_RX_PASS_FILTER) begin
        if (atype[0]) begin
          qualify = 1'b1; // see RULE1, RULE8
        end else if (atype == WFM_ATYPE_MCAST) begin
          qualify = mcast_q; // see RULE1, RULE8
        end else if (atype == WFM_ATYPE_UCAST) begin
          qualify = ~mcast_q; // see RULE1, RULE8
        end
      end
    end

    // Enabled filter, CRC equal to expected and address qualified
    assign hit[g] = cmd_q[g][WFM_CMD_ENABLE_BIT] & (crc_next == exp_crc_q[g]) & qualify; // see RULE2, RULE4

    // Running CRC over masked bytes
    always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
        crc_q[g] <= WFM_CRC_INIT;
      end else if (I_RX_VALID) begin
        crc_q[g] <= crc_next;
      end
    end
  end

  // Any filter hit at the last byte wakes, only with frame wake enabled
  assign frame_wake = frame_en_q & frame_end & (|hit); // see RULE5, RULE19

  // Magic packet at frame end for own, broadcast or multicast destination
  assign magic_evt = magic_en_q & frame_end & found_q & (da_self_q | mcast_q); // see RULE12

  // Magic packet search: skip addresses, find sync run, count copies
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      mg_state_q <= WFM_MG_HDR;
      hdr_cnt_q <= 4'h0;
      sync_cnt_q <= 3'h0;
      bidx_q <= 3'h0;
      copy_q <= 5'h00;
      found_q <= 1'b0;
    end else if (I_RX_VALID && magic_en_q) begin
      if (pos_q == 9'h000) begin
        mg_state_q <= WFM_MG_HDR;
        hdr_cnt_q <= 4'h1;
        sync_cnt_q <= 3'h0;
        bidx_q <= 3'h0;
        copy_q <= 5'h00;
        found_q <= 1'b0;
      end else begin
        case (mg_state_q)
          WFM_MG_HDR: begin
            if (hdr_cnt_q == WFM_HDR_BYTES - 4'h1) begin
              mg_state_q <= WFM_MG_SYNC; // see RULE13
              sync_cnt_q <= 3'h0;
            end else begin
              hdr_cnt_q <= hdr_cnt_q + 4'h1;
            end
          end
          WFM_MG_SYNC: begin
            if (I_RX_DATA == WFM_SYNC_BYTE) begin
              if (sync_cnt_q == WFM_SYNC_BYTES - 3'h1) begin
                mg_state_q <= WFM_MG_ADDR; // see RULE13, RULE16
                bidx_q <= 3'h0;
                copy_q <= 5'h00;
              end else begin
                sync_cnt_q <= sync_cnt_q + 3'h1;
              end
            end else begin
              sync_cnt_q <= 3'h0;
            end
          end
          WFM_MG_ADDR: begin
            if (I_RX_DATA == sta_byte[bidx_q]) begin
              if (bidx_q == WFM_ADDR_BYTES - 3'h1) begin
                bidx_q <= 3'h0;
                if (copy_q == WFM_ADDR_COPIES - 5'h01) begin
                  found_q <= 1'b1; // see RULE14
                  mg_state_q <= WFM_MG_SYNC;
                  sync_cnt_q <= 3'h0;
                end else begin
                  copy_q <= copy_q + 5'h01;
                end
              end else begin
                bidx_q <= bidx_q + 3'h1;
              end
            end else if (bidx_q == 3'h0 && copy_q == 5'h00 && I_RX_DATA == WFM_SYNC_BYTE) begin
              mg_state_q <= WFM_MG_ADDR; // Longer sync run, keep waiting
            end else begin
              mg_state_q <= WFM_MG_SYNC; // see RULE15
              sync_cnt_q <= (I_RX_DATA == WFM_SYNC_BYTE) ? 3'h1 : 3'h0;
              bidx_q <= 3'h0;
              copy_q <= 5'h00;
            end
          end
          default: begin
            mg_state_q <= WFM_MG_SYNC;
            sync_cnt_q <= 3'h0;
          end
        endcase
      end
    end
  end

  // Sticky interrupt status, clear register wins only without a new event
  assign irq_events = {magic_evt, frame_wake};

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr && !in_mask && I_PADDR[11:2] == WFM_REG_IRQ_CLEAR[11:2]) begin
      irq_stat_d = irq_stat_q & ~I_PWDATA[1:0];
    end
    irq_stat_d = irq_stat_d | irq_events;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      irq_stat_q <= WFM_IRQ_RESET;
      irq_en_q <= WFM_IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr && !in_mask && I_PADDR[11:2] == WFM_REG_IRQ_ENABLE[11:2]) begin
        irq_en_q <= I_PWDATA[1:0];
      end
    end
  end

  // Wake pulses and interrupt level
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      remote_wake_q <= 1'b0;
      full_power_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      remote_wake_q <= frame_wake | magic_evt; // see RULE10
      full_power_q <= magic_evt; // see RULE10
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_RX_SUPPRESS = magic_en_q; // see RULE9
  assign O_REMOTE_WAKE = remote_wake_q;
  assign O_FULL_POWER = full_power_q;
  assign O_IRQ = irq_q;

endmodule
`default_nettype wire

// ---- test/wfm_wake_detect_asserts.sv ----
// Port assertions for the wake detector
`timescale 1ns/1ps
`default_nettype none
module wfm_wake_detect_asserts (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_RX_VALID,
  input wire logic I_RX_LAST,
  input wire logic O_RX_SUPPRESS,
  input wire logic O_REMOTE_WAKE,
  input wire logic O_FULL_POWER,
  input wire logic O_IRQ
);
  // One domain, reset disables all
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);
  // Bus answer timing
  property p_rdy;
    I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_rdy_req;
    O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PSEL && I_PENABLE);
  endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("ready without request");
  property p_rdy_one;
    O_PREADY |=> !O_PREADY;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  property p_err;
    O_PSLVERR |-> O_PREADY;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // Wake pulses follow the last byte
  property p_wake;
    O_REMOTE_WAKE |-> $past(I_RX_VALID && I_RX_LAST) ##1 !O_REMOTE_WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse wrong");
  property p_full;
    O_FULL_POWER |-> O_REMOTE_WAKE && $past(O_RX_SUPPRESS);
  endproperty
  a_full: assert property (p_full) else $error("full power wrong");
  property p_supp;
    $changed(O_RX_SUPPRESS) |-> $past(I_SRST) || $past(O_PREADY && I_PWRITE);
  endproperty
  a_supp: assert property (p_supp) else $error("suppress moved alone");
  property p_irq_up;
    $rose(O_IRQ) |-> O_REMOTE_WAKE || $past(O_PREADY && I_PWRITE, 2);
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose alone");
  property p_irq_dn;
    $fell(O_IRQ) |-> $past(I_SRST) || $past(O_PREADY && I_PWRITE) || $past(O_PREADY && I_PWRITE, 2);
  endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell alone");
endmodule
`default_nettype wire

// ---- test/wfm_phy_model.sv ----
// PHY-side receive byte source
`timescale 1ns/1ps
`default_nettype none
module wfm_phy_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_last,
  output logic o_pass
);
  // Idle line at time zero
  initial begin
    o_valid = 1'b0;
    o_data = 8'h5A;
    o_last = 1'b0;
    o_pass = 1'b0;
  end
  // One frame; slow adds gaps, idle data keeps toggling
  task automatic send(input logic [7:0] fr[$], input logic pass, input logic slow);
    for (int i = 0; i < fr.size(); i++) begin
      repeat (slow ? i % 3 : 0) begin
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_data <= fr[i];
      o_last <= i == fr.size() - 1;
      o_pass <= pass;
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_last <= 1'b0;
    o_data <= ~o_data;
    o_pass <= ~pass;
  endtask
endmodule
`default_nettype wire

// ---- test/test_wake_frame_and_magic_detect.sv ----
// Self-checking bench for the wake detector
`timescale 1ns/1ps
`default_nettype none
module test_wake_frame_and_magic_detect
  import wfm_pkg::*;
;
  localparam logic [15:0] POLY = 16'h8005;
  logic clk;
  logic srst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_last;
  logic rx_pass;
  logic [47:0] station;
  logic suppress;
  logic wake;
  logic full;
  logic irq;
  logic er;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] m;
  logic [7:0] fr[$];
  int seed;
  int failures;
  int checks_done;
  int wake_n;
  int full_n;
  logic [11:0] regs [13] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
                             12'h020, 12'h030, 12'h038, 12'h100, 12'h13C};
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  wfm_wake_detect #(.CRC_POLY(POLY)) u_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data),
    .I_RX_LAST(rx_last), .I_RX_PASS_FILTER(rx_pass), .I_STATION_ADDR(station),
    .O_RX_SUPPRESS(suppress), .O_REMOTE_WAKE(wake), .O_FULL_POWER(full), .O_IRQ(irq));
  wfm_phy_model u_phy (.i_clk(clk), .o_valid(rx_valid), .o_data(rx_data), .o_last(rx_last), .o_pass(rx_pass));
  // Count wake pulses
  always @(posedge clk) begin
    if (wake === 1'b1) wake_n <= wake_n + 1;
    if (full === 1'b1) full_n <= full_n + 1;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk1(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reference CRC over masked window
  function automatic logic [15:0] crc_of(input logic [7:0] q[$], input logic [7:0] ofs, input logic [31:0] mk);
    logic [15:0] c;
    logic fb;
    c = 16'hFFFF;
    for (int j = 0; j < 32; j++) begin
      for (int b = 0; b < 8 && mk[j]; b++) begin
        fb = c[15] ^ q[ofs + j][b];
        c = (c << 1) ^ (fb ? POLY : 16'h0000);
      end
    end
    return c;
  endfunction
  // Expected frame wake; ok = wake enable, filter enable, crc match
  function automatic logic exp_wake(input logic [2:0] ok, input logic gu, input logic pass,
                                    input logic [1:0] at, input int cls);
    if (ok != 3'b111) return 1'b0;
    if (cls == 2 || (cls == 0 && gu)) return 1'b1;
    return pass && (at[0] || (at == 2'b10 && cls == 1) || (at == 2'b00 && cls == 0));
  endfunction
  // Frame building helpers
  task automatic put(input int n, input logic sync);
    for (int k = 0; k < 6 * n; k++) fr.push_back(sync ? 8'hFF : station[47 - 8 * (k % 6) -: 8]);
  endtask
  task automatic junk(input int n);
    repeat (n) fr.push_back(8'($random(seed)) & 8'h7F);
  endtask
  task automatic add_da(input int cls);
    fr = {};
    put(1, cls == 2);
    if (cls == 1) fr[0] = 8'h01;
    junk(6);
  endtask
  // Pattern filter frame
  task automatic frame_case(input int cls, input logic [1:0] at, input logic pass, input logic gu, input logic [2:0] ok);
    int f;
    int w0;
    logic [7:0] ofs;
    logic [15:0] c;
    logic e;
    f = $random(seed) & 7;
    ofs = 8'($random(seed)) & 8'h0F;
    m = $random(seed);
    add_da(cls);
    repeat (48) fr.push_back(8'($random(seed)));
    c = crc_of(fr, ofs, m) ^ {15'h0, ~ok[0]};
    e = exp_wake(ok, gu, pass, at, cls);
    apb(1'b1, WFM_REG_WAKE_CTRL_STATUS, {22'h0, gu, 2'h0, 2'h3, 2'h0, ok[2], 2'h0});
    apb(1'b1, f < 4 ? WFM_REG_CMD_LO : WFM_REG_CMD_HI, {28'h0, at, 1'b0, ok[1]} << 8 * (f % 4));
    apb(1'b1, f < 4 ? WFM_REG_CMD_HI : WFM_REG_CMD_LO, 32'h0);
    apb(1'b1, f < 4 ? WFM_REG_OFS_LO : WFM_REG_OFS_HI, {24'h0, ofs} << 8 * (f % 4));
    apb(1'b1, WFM_REG_CRC_01 + 12'(4 * (f / 2)), {16'h0, c} << 16 * (f % 2));
    apb(1'b1, 12'h100 + 12'(16 * f), m);
    w0 = wake_n;
    u_phy.send(fr, pass, f[0]);
    repeat (3) @(posedge clk);
    chk(wake_n - w0, {31'h0, e});
    chk1(irq, e);
    apb(1'b0, WFM_REG_WAKE_CTRL_STATUS, 32'h0);
    chk1(rd[WFM_FRAME_RCVD_BIT], e);
    apb(1'b1, WFM_REG_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0);
  endtask
  // Magic packet frame of a given kind
  task automatic magic_case(input int kind, input logic en, input logic e);
    int w0;
    int f0;
    add_da(kind == 1 ? 2 : kind == 2 ? 1 : 0);
    if (kind == 3) fr[5] = ~fr[5];
    for (int k = 6; k < 12 && kind == 6; k++) fr[k] = 8'hFF;
    junk(6);
    if (kind == 5) begin
      put(1, 1'b1);
      put(5, 1'b0);
      fr.push_back(~station[47:40]);
    end
    if (kind != 6) put(1, 1'b1);
    put(kind == 4 ? 15 : 16, 1'b0);
    repeat (4) fr.push_back(~station[47:40]);
    apb(1'b1, WFM_REG_WAKE_CTRL_STATUS, {25'h0, 2'h3, 3'h0, en, 1'b0});
    w0 = wake_n;
    f0 = full_n;
    u_phy.send(fr, 1'b0, kind[0]);
    repeat (3) @(posedge clk);
    chk(wake_n - w0, {31'h0, e});
    chk(full_n - f0, {31'h0, e});
    chk1(suppress, en);
    apb(1'b0, WFM_REG_WAKE_CTRL_STATUS, 32'h0);
    chk1(rd[WFM_MAGIC_RCVD_BIT], e);
    apb(1'b0, WFM_REG_IRQ_STATUS, 32'h0);
    chk1(rd[WFM_IRQ_MAGIC_BIT], e);
    chk1(irq, e);
    apb(1'b1, WFM_REG_IRQ_CLEAR, 32'h3);
    $display("magic kind %0d done", kind);
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    final_report();
  end
  // Main sequence
  initial begin
    seed = 39822;
    failures = 0;
    checks_done = 0;
    wake_n = 0;
    full_n = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    station = 48'({$random(seed), $random(seed)}) & 48'hFEFFFFFFFFFF;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      apb(1'b0, regs[i], 32'h0);
      chk(rd, 32'h0);
      chk1(er, 1'b0);
    end
    apb(1'b0, 12'h044, 32'h0);
    chk1(er, 1'b1);
    for (int i = 1; i < 13; i++) begin
      d = $random(seed);
      m = i < 3 ? 32'h0D0D0D0D : i == 9 ? 32'h0 : i == 10 ? 32'h3 : 32'hFFFFFFFF;
      apb(1'b1, regs[i], i == 9 ? d : d & m);
      apb(1'b0, regs[i], 32'h0);
      chk(rd, d & m);
    end
    $display("registers done");
    apb(1'b1, WFM_REG_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 48; i++) frame_case(i % 3, 2'(i / 3), 1'(i / 12), 1'(i / 24), 3'b111);
    for (int i = 0; i < 16; i++) begin
      frame_case($unsigned($random(seed)) % 3, 2'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                 3'($random(seed)));
    end
    $display("wake frames done");
    apb(1'b1, WFM_REG_IRQ_ENABLE, 32'h3);
    for (int k = 0; k < 7; k++) magic_case(k, 1'b1, k != 3 && k != 4 && k != 6);
    magic_case(0, 1'b0, 1'b0);
    final_report();
  end
endmodule
bind wfm_wake_detect wfm_wake_detect_asserts u_chk (.I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_RX_VALID(I_RX_VALID), .I_RX_LAST(I_RX_LAST), .O_RX_SUPPRESS(O_RX_SUPPRESS),
  .O_REMOTE_WAKE(O_REMOTE_WAKE), .O_FULL_POWER(O_FULL_POWER), .O_IRQ(O_IRQ));
`default_nettype wire
